//--- rtl/dmc_host.sv
// host-side controller for an asynchronous byte-wide dynamic memory
// assumes the strobes and data pins go straight to the memory; dq input
// arrives asynchronously and is resynchronised here
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"

module dmc_host
    import dmc_pkg::*;
#(
    parameter int REF_CYC = `DMC_REF_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic battery_backup_refresh,
    input wire logic req_valid,
    output logic req_ready,
    input wire dmc_req_s req,
    output logic rsp_valid,
    output logic [`DMC_DATA_W-1:0] rsp_rdata,
    output dmc_pins_s mem_pins,
    input wire logic [`DMC_DATA_W-1:0] data_pins_i
);

    typedef enum logic [3:0] {
        S_IDLE, S_ROW_SET, S_ROW, S_COL, S_CAS, S_TURN, S_LATE, S_WEND,
        S_PAGE, S_PRE, S_REF_C, S_REF_R, S_HID_RH, S_HID_RL
    } dmc_state_e;

    localparam dmc_pins_s PINS_IDLE = '{
        row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_sel_n: 1'b1,
        out_gate_n: 1'b1, multiplexed_addr_pins: '0, data_pins_o: '0,
        data_pins_oe: 1'b0};

    dmc_state_e state, next_state;
    dmc_pins_s next_pins;
    dmc_req_s cur, next_cur;
    logic [1:0] cnt, next_cnt;
    logic next_rsp_valid;
    logic [`DMC_DATA_W-1:0] next_rsp_rdata;
    logic [`DMC_DATA_W-1:0] dq_s1, dq_s2;
    logic ref_due, ref_ack;

    // the plain write is the only op that drops write select before the column
    function automatic logic early_wr(input dmc_op_e op);
        early_wr = (op == DMC_OP_WRITE);
    endfunction

    dmc_refresh_timer #(.REF_CYC(REF_CYC)) u_timer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ack(ref_ack),
        .due(ref_due)
    );

    ////////////////////////////////////////////////////////////////////////////
    // two-flop resync of the shared data pins before anything reads them
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= data_pins_i;
            dq_s2 <= dq_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: pins are registered, so each state shows what its entry set
    always_comb begin
        next_state = state;
        next_pins = mem_pins;
        next_cur = cur;
        next_cnt = cnt;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        req_ready = 1'b0;
        ref_ack = 1'b0;
        case (state)
            S_IDLE: begin
                if (ref_due) begin
                    // column first, so the memory picks the row itself
                    next_pins.col_strobe_n = 1'b0;
                    next_state = S_REF_C;
                end else if (req_valid && !battery_backup_refresh) begin
                    req_ready = 1'b1;
                    next_cur = req;
                    next_pins.multiplexed_addr_pins = req.row;
                    next_pins.write_sel_n = ~req.masked;
                    next_pins.data_pins_oe = req.masked;
                    next_pins.data_pins_o = req.mask;
                    next_state = S_ROW_SET;
                end
            end
            S_ROW_SET: begin
                next_pins.row_strobe_n = 1'b0;
                next_state = S_ROW;
            end
            S_ROW: begin
                // column address, and data ahead of the strobe for early write
                next_pins.multiplexed_addr_pins = `DMC_ROW_W'(cur.col);
                next_pins.write_sel_n = ~early_wr(cur.op);
                next_pins.data_pins_oe = early_wr(cur.op);
                next_pins.data_pins_o = cur.wdata;
                next_state = S_COL;
            end
            S_COL: begin
                next_pins.col_strobe_n = 1'b0;
                next_pins.out_gate_n = early_wr(cur.op);
                next_cnt = 2'(`DMC_SYNC_CYC);
                next_state = S_CAS;
            end
            S_CAS: begin
                if (early_wr(cur.op)) begin
                    next_pins.col_strobe_n = 1'b1;
                    next_pins.write_sel_n = 1'b1;
                    next_pins.data_pins_oe = 1'b0;
                    next_rsp_valid = 1'b1;
                    next_state = S_PAGE;
                end else if (cnt != 2'h0) begin
                    next_cnt = cnt - 2'h1;
                end else begin
                    next_rsp_rdata = dq_s2;
                    next_rsp_valid = 1'b1;
                    if (cur.op == DMC_OP_RMW) begin
                        // gate off first, and wait out the output turn-off
                        next_pins.out_gate_n = 1'b1;
                        next_cnt = 2'(`DMC_OUTPUT_TURNOFF_TIME_CYC - 1);
                        next_state = S_TURN;
                    end else if (ref_due) begin
                        // column stays low so the read data stays on the pins
                        next_pins.row_strobe_n = 1'b1;
                        next_state = S_HID_RH;
                    end else begin
                        next_pins.col_strobe_n = 1'b1;
                        next_pins.out_gate_n = 1'b1;
                        next_state = S_PAGE;
                    end
                end
            end
            S_TURN: begin
                if (cnt != 2'h0) begin
                    next_cnt = cnt - 2'h1;
                end else begin
                    next_pins.data_pins_oe = 1'b1;
                    next_pins.data_pins_o = cur.wdata;
                    next_state = S_LATE;
                end
            end
            S_LATE: begin
                next_pins.write_sel_n = 1'b0;
                next_state = S_WEND;
            end
            S_WEND: begin
                next_pins.col_strobe_n = 1'b1;
                next_pins.write_sel_n = 1'b1;
                next_pins.data_pins_oe = 1'b0;
                next_state = S_PAGE;
            end
            S_PAGE: begin
                // stay on the open row only for a waiting same-row request;
                // a masked request needs a new row fall to take its mask
                if (req_valid && !ref_due && !battery_backup_refresh &&
                    !req.masked && req.row == cur.row) begin
                    req_ready = 1'b1;
                    next_cur = req;
                    next_pins.multiplexed_addr_pins = `DMC_ROW_W'(req.col);
                    next_pins.write_sel_n = ~early_wr(req.op);
                    next_pins.data_pins_oe = early_wr(req.op);
                    next_pins.data_pins_o = req.wdata;
                    next_state = S_COL;
                end else begin
                    next_pins = PINS_IDLE;
                    next_state = S_PRE;
                end
            end
            S_PRE: begin
                next_state = S_IDLE; // one full cycle of precharge
            end
            S_REF_C: begin
                next_pins.row_strobe_n = 1'b0;
                ref_ack = 1'b1;
                next_state = S_REF_R;
            end
            S_REF_R: begin
                next_pins = PINS_IDLE;
                next_state = S_PRE;
            end
            S_HID_RH: begin
                next_pins.row_strobe_n = 1'b0;
                ref_ack = 1'b1;
                next_state = S_HID_RL;
            end
            S_HID_RL: begin
                next_pins = PINS_IDLE;
                next_state = S_PRE;
            end
            default: begin
                next_pins = PINS_IDLE;
                next_state = S_PRE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            mem_pins <= PINS_IDLE;
            cur <= '0;
            cnt <= 2'h0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            state <= next_state;
            mem_pins <= next_pins;
            cur <= next_cur;
            cnt <= next_cnt;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on the pin sequences
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_turn_then_write;
        !mem_pins.data_pins_oe ##1 mem_pins.data_pins_oe ##1 !mem_pins.write_sel_n;
    endsequence

    a_mask_at_row: assert property (
        $fell(mem_pins.row_strobe_n) && !mem_pins.write_sel_n |->
        mem_pins.data_pins_oe && mem_pins.data_pins_o == cur.mask)
        else $error("mask not driven at row fall");
    a_row_then_col: assert property (
        $fell(mem_pins.row_strobe_n) && mem_pins.col_strobe_n |->
        mem_pins.multiplexed_addr_pins == cur.row ##1
        mem_pins.multiplexed_addr_pins == `DMC_ROW_W'(cur.col))
        else $error("row or column address wrong");
    a_early_write: assert property (
        $fell(mem_pins.col_strobe_n) && !mem_pins.write_sel_n |->
        mem_pins.data_pins_oe && mem_pins.out_gate_n)
        else $error("early write without data or with gate on");
    a_no_fight: assert property (
        mem_pins.data_pins_oe |-> mem_pins.out_gate_n)
        else $error("data driven while output gate low");
    a_turn_gap: assert property (
        $rose(mem_pins.out_gate_n) && !mem_pins.col_strobe_n &&
        !mem_pins.row_strobe_n |-> s_turn_then_write)
        else $error("write data driven before turn-off");
    a_col_in_row: assert property (
        $fell(mem_pins.col_strobe_n) |->
        !mem_pins.row_strobe_n || state == S_REF_C || state == S_HID_RH)
        else $error("column strobe outside a row");
    a_refresh_order: assert property (
        $fell(mem_pins.row_strobe_n) && !mem_pins.col_strobe_n |->
        !$past(mem_pins.col_strobe_n) && $past(ref_ack) && ref_ack == 1'b0)
        else $error("refresh without column first");
    a_refresh_served: assert property (
        $rose(ref_due) |-> ##[1:40] ref_ack)
        else $error("refresh not served in time");
    a_precharge: assert property (
        $rose(mem_pins.row_strobe_n) && mem_pins.col_strobe_n |=>
        mem_pins.row_strobe_n)
        else $error("precharge shorter than one cycle");

endmodule

`default_nettype wire

//--- common/dmc_map.svh
// constants for the byte-wide dynamic memory host controller
// assumes a single 100 ns system clock; all counts are whole cycles of it
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

// address widths on the multiplexed pins, and the data pin width
`define DMC_ROW_W 10
`define DMC_COL_W 9
`define DMC_DATA_W 8

// clock period and pin timing
`define DMC_CLK_NS 100
`define DMC_OUTPUT_TURNOFF_TIME_NS 15
`define DMC_OUTPUT_TURNOFF_TIME_CYC (((`DMC_OUTPUT_TURNOFF_TIME_NS) + (`DMC_CLK_NS) - 1) / (`DMC_CLK_NS))
`define DMC_SYNC_CYC 2

// refresh: every row within the window, spread evenly
`define DMC_REF_ROWS 1024
`define DMC_REF_WIN_MS 128
`define DMC_REF_CYC (((`DMC_REF_WIN_MS) * 1000000 / (`DMC_REF_ROWS)) / (`DMC_CLK_NS))
`define DMC_REF_BOUND 40

`endif

//--- common/dmc_pkg.sv
// types shared by the memory host controller and its refresh timer
// assumes dmc_map.svh sits on the include path
`include "dmc_map.svh"

package dmc_pkg;

    typedef enum logic [1:0] {
        DMC_OP_READ,
        DMC_OP_WRITE,
        DMC_OP_RMW
    } dmc_op_e;

    // one user request; mask is used only when masked is set
    typedef struct packed {
        dmc_op_e op;
        logic masked;
        logic [`DMC_ROW_W-1:0] row;
        logic [`DMC_COL_W-1:0] col;
        logic [`DMC_DATA_W-1:0] wdata;
        logic [`DMC_DATA_W-1:0] mask;
    } dmc_req_s;

    // strobes, address and data drive toward the memory
    typedef struct packed {
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_sel_n;
        logic out_gate_n;
        logic [`DMC_ROW_W-1:0] multiplexed_addr_pins;
        logic [`DMC_DATA_W-1:0] data_pins_o;
        logic data_pins_oe;
    } dmc_pins_s;

endpackage

//--- rtl/dmc_refresh_timer.sv
// refresh interval timer: raises a sticky due flag once per row interval
// assumes ack is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"

module dmc_refresh_timer
    import dmc_pkg::*;
#(
    parameter int REF_CYC = `DMC_REF_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ack,
    output logic due
);

    generate
        if (REF_CYC < 2 || REF_CYC > 65535) begin : g_bad_cyc
            $error("refresh interval out of range");
        end
    endgenerate

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_due;
    logic wrap;

    ////////////////////////////////////////////////////////////////////////////
    // free-running interval; a tick that meets an ack keeps due set
    always_comb begin
        wrap = (cnt == 16'(REF_CYC - 1));
        next_cnt = wrap ? 16'h0000 : cnt + 16'h0001;
        next_due = wrap | (due & ~ack);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 16'h0000;
            due <= 1'b0;
        end else begin
            cnt <= next_cnt;
            due <= next_due;
        end
    end

    a_due_on_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrap |=> due) else $error("refresh tick did not raise due");

endmodule

`default_nettype wire

//--- tb/dmc_mem_model.sv
// behavioural byte-wide dynamic memory seen from its strobe and data pins
// assumes the host drives registered pins; no clock reaches the memory
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"

module dmc_mem_model
    import dmc_pkg::*;
(
    input wire dmc_pins_s pins,
    output logic [`DMC_DATA_W-1:0] dq,
    output logic drv,
    output logic [15:0] n_cbr,
    output logic [15:0] n_fault,
    output logic [15:0] n_hid
);
    logic [`DMC_DATA_W-1:0] mem [int];
    logic [`DMC_ROW_W-1:0] row = '0;
    logic [`DMC_ROW_W-1:0] ref_row = '0;
    logic [`DMC_COL_W-1:0] col = '0;
    logic [`DMC_DATA_W-1:0] mask = '0;
    logic [`DMC_DATA_W-1:0] q = '0;
    logic masked = 1'h0;
    logic q_ok = 1'h0;

    initial begin
        n_cbr = '0;
        n_fault = '0;
        n_hid = '0;
    end

    function automatic int addr();
        return int'({row, col});
    endfunction

    // masked bits keep the old cell value
    task automatic store();
        logic [`DMC_DATA_W-1:0] old;
        old = mem.exists(addr()) ? mem[addr()] : 8'h00;
        mem[addr()] = masked ? ((old & ~mask) | (pins.data_pins_o & mask)) : pins.data_pins_o;
    endtask

    // row fall: column low means refresh from the own counter, else latch row
    always @(negedge pins.row_strobe_n) begin
        if (pins.col_strobe_n === 1'h0) begin
            n_cbr <= n_cbr + 16'h1;
            ref_row <= ref_row + 10'h1;
            // still presenting read data means the refresh was hidden
            if (drv === 1'h1) begin
                n_hid <= n_hid + 16'h1;
            end
        end else begin
            row = pins.multiplexed_addr_pins;
            masked = !pins.write_sel_n;
            mask = pins.data_pins_o;
            q_ok = 1'h0;
            if (masked && !pins.data_pins_oe) begin
                n_fault <= n_fault + 16'h1;
            end
        end
    end

    // column fall: latch column, fetch data, early write stores here
    always @(negedge pins.col_strobe_n) begin
        if (pins.row_strobe_n === 1'h0) begin
            col = pins.multiplexed_addr_pins[`DMC_COL_W-1:0];
            q = mem.exists(addr()) ? mem[addr()] : 8'h00;
            q_ok = pins.write_sel_n;
            if (!pins.write_sel_n) begin
                store();
            end
        end
    end

    // late write: data taken when write select falls after the column
    always @(negedge pins.write_sel_n) begin
        if (!pins.row_strobe_n && !pins.col_strobe_n) begin
            store();
        end
    end

    // column high closes the output buffer; row high alone keeps it
    always @(posedge pins.col_strobe_n) begin
        q_ok = 1'h0;
    end

    // released pins show the inverse, never a stale copy of the data
    assign drv = q_ok && !pins.col_strobe_n && !pins.out_gate_n && pins.write_sel_n;
    assign dq = pins.data_pins_oe ? pins.data_pins_o : (drv ? q : ~q);
endmodule

`default_nettype wire

//--- tb/dmc_host_tb.sv
// self-checking bench for the memory host controller
// assumes the memory model in dmc_mem_model.sv sits on the pins
`timescale 1ns/1ns
`default_nettype none
`include "dmc_map.svh"

module dmc_host_tb
    import dmc_pkg::*;
;
    localparam int REF = 200; // shortened refresh interval
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic bbr = 1'h0;
    logic req_valid = 1'h0;
    logic req_ready;
    logic rsp_valid;
    logic drv;
    dmc_req_s req = '0;
    logic [`DMC_DATA_W-1:0] rsp_rdata;
    logic [`DMC_DATA_W-1:0] dq;
    dmc_pins_s mem_pins;
    logic [15:0] n_cbr;
    logic [15:0] n_fault;
    logic [15:0] n_hid;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] rq[$];
    int rc[$];

    always #50 ref_clk = ~ref_clk;

    dmc_host #(.REF_CYC(REF)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .battery_backup_refresh(bbr), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_pins(mem_pins),
        .data_pins_i(dq));
    dmc_mem_model mem (.pins(mem_pins), .dq(dq), .drv(drv), .n_cbr(n_cbr), .n_fault(n_fault),
        .n_hid(n_hid));

    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // response log and pin contention watch, sampled on every rising edge
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rsp_valid === 1'h1) begin
            rq.push_back(rsp_rdata);
            rc.push_back(cyc);
        end
        if (mem_pins.data_pins_oe === 1'h1 && drv === 1'h1) begin
            check(1, 0);
        end
    end

    // hold keeps valid up so the next request waits on an open page
    task automatic do_req(input dmc_op_e op, input logic m, input logic [9:0] r,
            input logic [8:0] c, input logic [7:0] d, input logic [7:0] k,
            input bit hold, output int t);
        req = '{op: op, masked: m, row: r, col: c, wdata: d, mask: k};
        req_valid = 1'h1;
        t = -1;
        for (int i = 0; i < 80 && t < 0; i++) begin
            @(posedge ref_clk);
            if (req_ready === 1'h1) t = cyc;
        end
        #1;
        if (!hold) req_valid = 1'h0;
        if (t < 0) check(0, 1);
    endtask

    // gap afterwards so the page closes before the next request
    task automatic wait_rsp(input int t, input int lat, input logic [7:0] d, input bit cd);
        for (int i = 0; i < 60 && rq.size() == 0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (rq.size() == 0) begin
            check(0, 1);
        end else begin
            check(rc.pop_front() - t, lat);
            if (cd) check(rq.pop_front(), d);
            else void'(rq.pop_front());
        end
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    ////////////////////////////////////////
    task automatic t_rw();
        int t;
        do_req(DMC_OP_WRITE, 0, 10'h3ff, 9'h1ff, 8'h3c, 8'h00, 0, t);
        wait_rsp(t, 5, 8'h00, 0);
        do_req(DMC_OP_WRITE, 0, 10'h3ff, 9'h000, 8'hc3, 8'h00, 0, t);
        wait_rsp(t, 5, 8'h00, 0);
        do_req(DMC_OP_READ, 0, 10'h3ff, 9'h1ff, 8'h00, 8'h00, 0, t);
        wait_rsp(t, 7, 8'h3c, 1);
        do_req(DMC_OP_READ, 0, 10'h3ff, 9'h000, 8'h00, 8'h00, 0, t);
        wait_rsp(t, 7, 8'hc3, 1);
    endtask

    task automatic t_mask();
        int t;
        do_req(DMC_OP_WRITE, 0, 10'h001, 9'h055, 8'ha5, 8'h00, 0, t);
        wait_rsp(t, 5, 8'h00, 0);
        do_req(DMC_OP_WRITE, 1, 10'h001, 9'h055, 8'h5a, 8'h0f, 0, t);
        wait_rsp(t, 5, 8'h00, 0);
        do_req(DMC_OP_WRITE, 1, 10'h001, 9'h055, 8'h00, 8'hf0, 0, t);
        wait_rsp(t, 5, 8'h00, 0);
        do_req(DMC_OP_READ, 0, 10'h001, 9'h055, 8'h00, 8'h00, 0, t);
        wait_rsp(t, 7, 8'h0a, 1);
    endtask

    task automatic t_rmw();
        int t;
        do_req(DMC_OP_WRITE, 0, 10'h200, 9'h100, 8'h11, 8'h00, 0, t);
        wait_rsp(t, 5, 8'h00, 0);
        do_req(DMC_OP_RMW, 0, 10'h200, 9'h100, 8'h77, 8'h00, 0, t);
        wait_rsp(t, 7, 8'h11, 1);
        do_req(DMC_OP_READ, 0, 10'h200, 9'h100, 8'h00, 8'h00, 0, t);
        wait_rsp(t, 7, 8'h77, 1);
    endtask

    // four requests queued on one row: only the first opens it
    task automatic t_page();
        int t[4];
        do_req(DMC_OP_WRITE, 0, 10'h2aa, 9'h003, 8'h44, 8'h00, 1, t[0]);
        do_req(DMC_OP_WRITE, 0, 10'h2aa, 9'h004, 8'h55, 8'h00, 1, t[1]);
        do_req(DMC_OP_READ, 0, 10'h2aa, 9'h003, 8'h00, 8'h00, 1, t[2]);
        do_req(DMC_OP_READ, 0, 10'h2aa, 9'h004, 8'h00, 8'h00, 0, t[3]);
        wait_rsp(t[0], 5, 8'h00, 0);
        wait_rsp(t[1], 3, 8'h00, 0);
        wait_rsp(t[2], 5, 8'h44, 1);
        wait_rsp(t[3], 5, 8'h55, 1);
    endtask

    // idle refresh rate, then battery backup refuses all requests
    task automatic t_refresh();
        logic [15:0] n0;
        int t;
        int k;
        logic [15:0] h0;
        k = 0;
        n0 = n_cbr;
        repeat (3 * REF) @(posedge ref_clk);
        #1;
        check((n_cbr - n0) inside {[2:4]}, 1);
        // line a read up so the next tick lands in its column phase
        n0 = n_cbr;
        wait (n_cbr != n0);
        repeat (REF - 6) @(posedge ref_clk);
        #1;
        h0 = n_hid;
        do_req(DMC_OP_READ, 0, 10'h3ff, 9'h000, 8'h00, 8'h00, 0, t);
        wait_rsp(t, 7, 8'hc3, 1);
        check(n_hid - h0, 1);
        n0 = n_cbr;
        bbr = 1'h1;
        req_valid = 1'h1;
        repeat (2 * REF) begin
            @(posedge ref_clk);
            if (req_ready !== 1'h0) k++;
        end
        #1;
        req_valid = 1'h0;
        bbr = 1'h0;
        check(k, 0);
        check((n_cbr - n0) inside {[1:3]}, 1);
        @(posedge ref_clk);
        #1;
        do_req(DMC_OP_READ, 0, 10'h3ff, 9'h1ff, 8'h00, 8'h00, 0, t);
        wait_rsp(t, 7, 8'h3c, 1);
    endtask

    ////////////////////////////////////////
    initial begin
        @(posedge ref_clk);
        #1;
        check(mem_pins.row_strobe_n, 1);
        check(mem_pins.col_strobe_n, 1);
        check(mem_pins.data_pins_oe, 0);
        @(posedge ref_clk);
        #1;
        sys_rst = 1'h0;
        t_rw();
        t_mask();
        t_rmw();
        t_page();
        t_refresh();
        check(n_fault, 0);
        finish_test();
    end

    // watchdog well past the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test();
    end
endmodule

`default_nettype wire
